// *** sswg_consts.svh ***
// Offsets, reset values, field positions and widths of the sub-frame window generator
// Behaviour
// - The data-capture window opens when the sub-frame count reaches the capture begin value.
// - The data-capture window closes at the capture finish count, which resets to 2648h.
// - The overload watch window opens at the overload begin count, which resets to 3E8h.
// - The overload watch window closes at the overload finish count, which resets to 1F40h.
// - The light enable window opens at the light begin count, which resets to zero.
// - The light enable window closes at the light finish count, which resets to 2134h.
// - Bits 23:16 of each window register read as zero and software writes only zero there.
// - Each sub-frame lasts subframe_length clocks, taken from an input port that has no reset value.
// - The timing generator runs and drives the windows only while its enable is one.
// - Each window lasts its finish count minus its begin count, in clock periods, when begin is below finish and finish does not exceed subframe_length.
`ifndef SSWG_CONSTS_SVH
`define SSWG_CONSTS_SVH

`define SSWG_ADDR_W 8
`define SSWG_DATA_W 24
`define SSWG_CNT_W 16
`define SSWG_FIELD_MSB 15
`define SSWG_RSVD_MSB 23
`define SSWG_RSVD_LSB 16

`define SSWG_OFS_CAPTURE_BEGIN 8'h87
`define SSWG_OFS_CAPTURE_FINISH 8'h88
`define SSWG_OFS_OVERLOAD_BEGIN 8'h89
`define SSWG_OFS_OVERLOAD_FINISH 8'h8a
`define SSWG_OFS_LIGHT_BEGIN 8'h8f
`define SSWG_OFS_LIGHT_FINISH 8'h90

`define SSWG_RST_CAPTURE_BEGIN 16'h2454
`define SSWG_RST_CAPTURE_FINISH 16'h2648
`define SSWG_RST_OVERLOAD_BEGIN 16'h03e8
`define SSWG_RST_OVERLOAD_FINISH 16'h1f40
`define SSWG_RST_LIGHT_BEGIN 16'h0000
`define SSWG_RST_LIGHT_FINISH 16'h2134
`define SSWG_RST_SUBFRAME_LENGTH 16'h270f

`endif

// *** sswg_pkg.sv ***
// Types of the sub-frame window generator
package sswg_pkg;
    typedef enum logic [1:0] {
        SSWG_IDLE = 2'b00,
        SSWG_RUN = 2'b01
    } sswg_state_t;
endpackage : sswg_pkg

// *** sswg_cfg_reg.sv ***
// One 16-bit window position register with its own reset value
`timescale 1ns/1ps
`include "sswg_consts.svh"
module sswg_cfg_reg #(
    parameter logic [`SSWG_CNT_W-1:0] RESET_VALUE = 16'h0000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [`SSWG_CNT_W-1:0] wr_data,
    output logic [`SSWG_CNT_W-1:0] value_q
);
    logic [`SSWG_CNT_W-1:0] value_d;

    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end
endmodule : sswg_cfg_reg

// *** sswg_window.sv ***
// Window comparator: on while begin <= count < finish, registered
`timescale 1ns/1ps
`include "sswg_consts.svh"
module sswg_window (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run_d,
    input wire logic [`SSWG_CNT_W-1:0] count_d,
    input wire logic [`SSWG_CNT_W-1:0] win_begin,
    input wire logic [`SSWG_CNT_W-1:0] win_finish,
    output logic active_q
);
    logic active_d;

    // Compared against the next count so the output lines up with the count register
    always_comb begin
        active_d = run_d && (count_d >= win_begin) && (count_d < win_finish);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end
endmodule : sswg_window

// *** sswg_top.sv ***
// Sub-frame counter, window registers and the three timing windows
`timescale 1ns/1ps
`include "sswg_consts.svh"
module sswg_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic timing_unit_enable,
    input wire logic [`SSWG_CNT_W-1:0] subframe_length,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`SSWG_ADDR_W-1:0] reg_addr,
    input wire logic [`SSWG_DATA_W-1:0] reg_wdata,
    output logic [`SSWG_DATA_W-1:0] reg_rdata,
    output logic [`SSWG_CNT_W-1:0] subframe_count,
    output logic capture_window,
    output logic overload_watch,
    output logic light_enable
);
    logic rst_meta_q;
    logic rst_n;
    sswg_pkg::sswg_state_t state_q;
    sswg_pkg::sswg_state_t state_d;
    logic [`SSWG_CNT_W-1:0] count_q;
    logic [`SSWG_CNT_W-1:0] count_d;
    logic [`SSWG_CNT_W:0] count_inc;
    logic run_d;
    logic last_clock;
    logic [`SSWG_DATA_W-1:0] rdata_d;
    logic [`SSWG_DATA_W-1:0] rdata_q;
    logic [`SSWG_CNT_W-1:0] wr_field;
    logic [`SSWG_CNT_W-1:0] capture_window_begin;
    logic [`SSWG_CNT_W-1:0] capture_window_finish;
    logic [`SSWG_CNT_W-1:0] overload_watch_begin;
    logic [`SSWG_CNT_W-1:0] overload_watch_finish;
    logic [`SSWG_CNT_W-1:0] light_enable_begin;
    logic [`SSWG_CNT_W-1:0] light_enable_finish;
    logic [`SSWG_CNT_W-1:0] capture_begin_d;
    logic [`SSWG_CNT_W-1:0] capture_finish_d;
    logic [`SSWG_CNT_W-1:0] overload_begin_d;
    logic [`SSWG_CNT_W-1:0] overload_finish_d;
    logic [`SSWG_CNT_W-1:0] light_begin_d;
    logic [`SSWG_CNT_W-1:0] light_finish_d;

    // Reset release synchroniser; assertion stays asynchronous
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Reserved upper byte of a write is dropped
    assign wr_field = reg_wdata[`SSWG_FIELD_MSB:0];

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_CAPTURE_BEGIN)
    ) u_capture_begin (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_CAPTURE_BEGIN)),
        .wr_data(wr_field),
        .value_q(capture_window_begin)
    );

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_CAPTURE_FINISH)
    ) u_capture_finish (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_CAPTURE_FINISH)),
        .wr_data(wr_field),
        .value_q(capture_window_finish)
    );

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_OVERLOAD_BEGIN)
    ) u_overload_begin (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_OVERLOAD_BEGIN)),
        .wr_data(wr_field),
        .value_q(overload_watch_begin)
    );

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_OVERLOAD_FINISH)
    ) u_overload_finish (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_OVERLOAD_FINISH)),
        .wr_data(wr_field),
        .value_q(overload_watch_finish)
    );

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_LIGHT_BEGIN)
    ) u_light_begin (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_LIGHT_BEGIN)),
        .wr_data(wr_field),
        .value_q(light_enable_begin)
    );

    sswg_cfg_reg #(
        .RESET_VALUE(`SSWG_RST_LIGHT_FINISH)
    ) u_light_finish (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && (reg_addr == `SSWG_OFS_LIGHT_FINISH)),
        .wr_data(wr_field),
        .value_q(light_enable_finish)
    );

    // Read data; reserved byte and unmapped offsets return zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            case (reg_addr)
                `SSWG_OFS_CAPTURE_BEGIN: rdata_d = {8'h00, capture_window_begin};
                `SSWG_OFS_CAPTURE_FINISH: rdata_d = {8'h00, capture_window_finish};
                `SSWG_OFS_OVERLOAD_BEGIN: rdata_d = {8'h00, overload_watch_begin};
                `SSWG_OFS_OVERLOAD_FINISH: rdata_d = {8'h00, overload_watch_finish};
                `SSWG_OFS_LIGHT_BEGIN: rdata_d = {8'h00, light_enable_begin};
                `SSWG_OFS_LIGHT_FINISH: rdata_d = {8'h00, light_enable_finish};
                default: rdata_d = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 24'h000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Sub-frame counter; a length of zero or one holds the count at zero
    always_comb begin
        count_inc = {1'b0, count_q} + 17'h00001;
        last_clock = (count_inc >= {1'b0, subframe_length});
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            sswg_pkg::SSWG_IDLE: begin
                count_d = 16'h0000;
                if (timing_unit_enable) begin
                    state_d = sswg_pkg::SSWG_RUN;
                end
            end
            sswg_pkg::SSWG_RUN: begin
                if (!timing_unit_enable) begin
                    state_d = sswg_pkg::SSWG_IDLE;
                    count_d = 16'h0000;
                end else if (last_clock) begin
                    count_d = 16'h0000;
                end else begin
                    count_d = count_inc[`SSWG_CNT_W-1:0];
                end
            end
            default: begin
                state_d = sswg_pkg::SSWG_IDLE;
                count_d = 16'h0000;
            end
        endcase
        run_d = (state_d == sswg_pkg::SSWG_RUN);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sswg_pkg::SSWG_IDLE;
            count_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign subframe_count = count_q;

    // Next register values; a write counts in the edge it lands, so windows never lag it
    always_comb begin
        capture_begin_d = capture_window_begin;
        capture_finish_d = capture_window_finish;
        overload_begin_d = overload_watch_begin;
        overload_finish_d = overload_watch_finish;
        light_begin_d = light_enable_begin;
        light_finish_d = light_enable_finish;
        if (reg_wr_en) begin
            case (reg_addr)
                `SSWG_OFS_CAPTURE_BEGIN: capture_begin_d = wr_field;
                `SSWG_OFS_CAPTURE_FINISH: capture_finish_d = wr_field;
                `SSWG_OFS_OVERLOAD_BEGIN: overload_begin_d = wr_field;
                `SSWG_OFS_OVERLOAD_FINISH: overload_finish_d = wr_field;
                `SSWG_OFS_LIGHT_BEGIN: light_begin_d = wr_field;
                `SSWG_OFS_LIGHT_FINISH: light_finish_d = wr_field;
                default: capture_begin_d = capture_window_begin;
            endcase
        end
    end

    // Disabled unit keeps every window low
    sswg_window u_capture_win (
        .clock(clock),
        .rst_n(rst_n),
        .run_d(run_d),
        .count_d(count_d),
        .win_begin(capture_begin_d),
        .win_finish(capture_finish_d),
        .active_q(capture_window)
    );

    sswg_window u_overload_win (
        .clock(clock),
        .rst_n(rst_n),
        .run_d(run_d),
        .count_d(count_d),
        .win_begin(overload_begin_d),
        .win_finish(overload_finish_d),
        .active_q(overload_watch)
    );

    sswg_window u_light_win (
        .clock(clock),
        .rst_n(rst_n),
        .run_d(run_d),
        .count_d(count_d),
        .win_begin(light_begin_d),
        .win_finish(light_finish_d),
        .active_q(light_enable)
    );

    // Checks
    chk_capture_open: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == sswg_pkg::SSWG_RUN) && (count_q == capture_window_begin)
            && (capture_window_begin < capture_window_finish) |-> capture_window)
        else $error("capture window not open at begin count");

    chk_capture_close: assert property (
        @(posedge clock) disable iff (!rst_n)
        (count_q == capture_window_finish) |-> !capture_window)
        else $error("capture window still open at finish count");

    chk_overload_open: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == sswg_pkg::SSWG_RUN) && (count_q == overload_watch_begin)
            && (overload_watch_begin < overload_watch_finish) |-> overload_watch)
        else $error("overload window not open at begin count");

    chk_overload_close: assert property (
        @(posedge clock) disable iff (!rst_n)
        (count_q == overload_watch_finish) |-> !overload_watch)
        else $error("overload window still open at finish count");

    chk_light_open: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == sswg_pkg::SSWG_RUN) && (count_q == light_enable_begin)
            && (light_enable_begin < light_enable_finish) |-> light_enable)
        else $error("light enable not raised at begin count");

    chk_light_close: assert property (
        @(posedge clock) disable iff (!rst_n)
        (count_q == light_enable_finish) |-> !light_enable)
        else $error("light enable still high at finish count");

    chk_reserved_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        reg_rd_en |=> (reg_rdata[`SSWG_RSVD_MSB:`SSWG_RSVD_LSB] == 8'h00))
        else $error("reserved read bits not zero");

    chk_readback_value: assert property (
        @(posedge clock) disable iff (!rst_n)
        reg_rd_en && !reg_wr_en && (reg_addr == `SSWG_OFS_CAPTURE_FINISH)
            |=> (reg_rdata[`SSWG_FIELD_MSB:0] == $past(capture_window_finish)))
        else $error("capture finish readback mismatch");

    chk_count_wrap: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == sswg_pkg::SSWG_RUN) && timing_unit_enable && last_clock
            |=> (count_q == 16'h0000))
        else $error("sub-frame counter did not wrap at length");

    chk_count_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == sswg_pkg::SSWG_RUN) && timing_unit_enable && !last_clock
            |=> (count_q == $past(count_q) + 16'h0001))
        else $error("sub-frame counter did not advance by one");

    chk_disabled_quiet: assert property (
        @(posedge clock) disable iff (!rst_n)
        !timing_unit_enable |=> !capture_window && !overload_watch && !light_enable
            && (count_q == 16'h0000))
        else $error("window active while timing unit disabled");

    chk_window_span: assert property (
        @(posedge clock) disable iff (!rst_n)
        capture_window |-> (count_q >= capture_window_begin)
            && (count_q < capture_window_finish))
        else $error("capture window outside its span");

endmodule : sswg_top

// *** sswg_tb.sv ***
// Self-checking bench for the sub-frame window generator
`timescale 1ns/1ps
`include "sswg_consts.svh"
module tb;
    localparam int LEN = 20;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic timing_unit_enable = 1'b0;
    logic [`SSWG_CNT_W-1:0] subframe_length = LEN[`SSWG_CNT_W-1:0];
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [`SSWG_ADDR_W-1:0] reg_addr = 8'h00;
    logic [`SSWG_DATA_W-1:0] reg_wdata = 24'h000000;
    logic [`SSWG_DATA_W-1:0] reg_rdata;
    logic [`SSWG_CNT_W-1:0] subframe_count;
    logic capture_window;
    logic overload_watch;
    logic light_enable;
    int failures = 0;
    int check_count = 0;
    logic [`SSWG_ADDR_W-1:0] ofs [6];
    logic [`SSWG_DATA_W-1:0] dflt [6];
    logic [`SSWG_CNT_W-1:0] wv [6];
    logic [`SSWG_DATA_W-1:0] rv;
    logic [`SSWG_CNT_W-1:0] c;

    sswg_top i_sswg_top (
        .clock(clock),
        .resetn(resetn),
        .timing_unit_enable(timing_unit_enable),
        .subframe_length(subframe_length),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .subframe_count(subframe_count),
        .capture_window(capture_window),
        .overload_watch(overload_watch),
        .light_enable(light_enable)
    );

    always #12.5 clock = ~clock;

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Strobes drop at the next falling edge, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd

    task automatic results();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Own model of the count; windows follow begin <= count < finish
    task automatic run_cycles(input int n, input logic [15:0] cb, input logic [15:0] cf,
                              input logic [15:0] ob, input logic [15:0] of,
                              input logic [15:0] lb, input logic [15:0] lf);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            check("count", 24'(subframe_count), 24'(c));
            check("capture", 24'(capture_window), 24'(c >= cb && c < cf));
            check("overload", 24'(overload_watch), 24'(c >= ob && c < of));
            check("light", 24'(light_enable), 24'(c >= lb && c < lf));
            c = (c == LEN - 1) ? 16'h0000 : c + 16'h0001;
        end
    endtask : run_cycles

    initial begin
        #(25 * 3000);
        failures++;
        results();
    end

    initial begin
        ofs = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8f, 8'h90};
        dflt = '{24'h002454, 24'h002648, 24'h0003e8, 24'h001f40, 24'h000000, 24'h002134};
        wv = '{16'h0003, 16'h0007, 16'h0005, 16'h000c, 16'h0000, 16'h0013};
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        check("idle count", 24'(subframe_count), 24'h000000);
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rv);
            check("default", rv, dflt[i]);
        end
        rd(8'h8b, rv);
        check("unmapped read", rv, 24'h000000);
        wr(8'h8b, 24'h001234);
        rd(8'h8b, rv);
        check("unmapped write", rv, 24'h000000);
        // Software keeps the reserved byte at zero on every write
        wr(8'h87, 24'h000003);
        rd(8'h87, rv);
        check("reserved bits", rv, 24'h000003);
        wr(8'h88, 24'h000007);
        wr(8'h89, 24'h000005);
        wr(8'h8a, 24'h00000c);
        wr(8'h8f, 24'h000000);
        wr(8'h90, 24'h000013);
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rv);
            check("readback", rv[15:0], wv[i]);
            check("readback top", rv[23:16], 8'h00);
        end
        rd(8'h90, rv);
        check("light finish", rv, 24'h000013);
        @(negedge clock);
        timing_unit_enable = 1'b1;
        c = 16'h0000;
        run_cycles(2 * LEN + 7, 16'h3, 16'h7, 16'h5, 16'hc, 16'h0, 16'h13);
        // Mid-run change of a finish takes effect at once
        wr(8'h88, 24'h000012);
        c = c + 16'h0002;
        if (c >= LEN) begin
            c = c - LEN;
        end
        run_cycles(LEN + 3, 16'h3, 16'h12, 16'h5, 16'hc, 16'h0, 16'h13);
        timing_unit_enable = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            check("off count", 24'(subframe_count), 24'h000000);
            check("off windows", 24'({capture_window, overload_watch, light_enable}), 24'h0);
        end
        results();
    end
endmodule : tb
